// file: pkg/gripper_if.sv
// cyclic process-data link between controller and gripper
`timescale 1ns/1ps
`default_nettype none
interface gripper_if;
  import gripper_pkg::*;
  word_t host_command_word;
  logic [7:0] operating_profile_code;
  word_t outer_limit_setpoint;
  word_t inner_limit_setpoint;
  word_t taught_target_setpoint;
  logic [7:0] window_half_width;
  logic [7:0] speed_percent_setpoint;
  word_t status_flags_word;
  word_t fault_code_word;
  word_t jaw_position_word;
  modport gripper(input host_command_word, operating_profile_code, outer_limit_setpoint,
    inner_limit_setpoint, taught_target_setpoint, window_half_width, speed_percent_setpoint,
    output status_flags_word, fault_code_word, jaw_position_word);
  modport controller(output host_command_word, operating_profile_code, outer_limit_setpoint,
    inner_limit_setpoint, taught_target_setpoint, window_half_width, speed_percent_setpoint,
    input status_flags_word, fault_code_word, jaw_position_word);
endinterface
`default_nettype wire

// file: pkg/gripper_map.svh
// register fields, mode codes and timing constants of the gripper process-data block
`ifndef GRIPPER_MAP_SVH
`define GRIPPER_MAP_SVH
`define ST_REF_OK 0
`define ST_MOTOR 1
`define ST_IN_MOTION 2
`define ST_DONE 3
`define ST_PLC_ACTIVE 6
`define ST_AT_OUTER 8
`define ST_AT_TAUGHT 9
`define ST_AT_INNER 10
`define ST_NO_WINDOW 11
`define ST_XFER_ACK 12
`define ST_DIR_OUTER 13
`define ST_DIR_INNER 14
`define ST_ERROR 15
`define CMD_XFER 16'h0001
`define CMD_IDLE 16'h0000
`define MODE_MOTOR_ON 8'h03
`define MODE_HOME_OUT 8'h0A
`define MODE_HOME_IN 8'h0E
`define MODE_HOME_EXT_OUT 8'h10
`define MODE_HOME_EXT_IN 8'h11
`define FAULT_NONE 16'h0000
`define FAULT_BAD_MODE 16'h0101
`define FAULT_BAD_BASE 16'h0102
`define FAULT_HOME_GRIPPED 16'h0103
`define MIN_EXT_BASE 16'h004B
`define POS_ZERO 16'h0000
`define BOOT_CYCLES 16
`define STEP_CYCLES 4
// controller-side user register addresses
`define CR_MODE 4'h0
`define CR_BASE 4'h1
`define CR_WORK 4'h2
`define CR_TEACH 4'h3
`define CR_TOL 4'h4
`define CR_SPEED 4'h5
`define CR_GO 4'h6
`define CR_STATUS 4'h8
`define CR_FAULT 4'h9
`define CR_POS 4'hA
`define CR_CTRL 4'hB
`define CTRL_GO_BIT 0
`define CTRL_BUSY_BIT 1
`endif

// file: pkg/gripper_pkg.sv
// shared types of the gripper process-data block
package gripper_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    DV_BOOT = 3'b000,
    DV_IDLE = 3'b001,
    DV_HOME_RUN = 3'b011,
    DV_ACK = 3'b010,
    DV_WAIT_CLR = 3'b110
  } dev_state_e;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SEND = 2'b01,
    HS_CLEAR = 2'b11
  } host_state_e;
endpackage

// file: rtl/gripper_controller.sv
// controller end: user registers drive the parameter handshake over the link
`timescale 1ns/1ps
`default_nettype none
`include "gripper_map.svh"
module gripper_controller
  import gripper_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // user register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // link
  gripper_if.controller link
);
  host_state_e hs_q, hs_d;
  logic [7:0] mode_q, mode_d, tol_q, tol_d, spd_q, spd_d;
  word_t base_q, base_d, work_q, work_d, teach_q, teach_d, rdata_q, rdata_d;
  logic go_q, go_d;
  logic ack_seen;

  // the ack comes from logic on this same clock, so it needs no synchroniser
  assign ack_seen = link.status_flags_word[`ST_XFER_ACK];

  always_comb begin
    hs_d = hs_q;
    mode_d = mode_q;
    tol_d = tol_q;
    spd_d = spd_q;
    base_d = base_q;
    work_d = work_q;
    teach_d = teach_q;
    go_d = go_q;
    rdata_d = 16'h0000;
    if (wr_i && hs_q == HS_IDLE) begin
      unique case (addr_i)
        `CR_MODE: mode_d = wdata_i[7:0];
        `CR_BASE: base_d = wdata_i;
        `CR_WORK: work_d = wdata_i;
        `CR_TEACH: teach_d = wdata_i;
        `CR_TOL: tol_d = wdata_i[7:0];
        `CR_SPEED: spd_d = wdata_i[7:0];
        `CR_GO: go_d = 1'b1;
        default: ;
      endcase
    end
    // homing refused while gripped is left to software; base below 75 is raised here in mode 16 only
    if (base_d < `MIN_EXT_BASE && (mode_d == `MODE_HOME_EXT_OUT)) begin
      base_d = `MIN_EXT_BASE;
    end
    unique case (hs_q)
      HS_IDLE: if (go_q) hs_d = HS_SEND;
      HS_SEND: if (ack_seen) hs_d = HS_CLEAR;
      HS_CLEAR: begin
        if (!ack_seen) begin
          go_d = 1'b0;
          hs_d = HS_IDLE;
        end
      end
      default: hs_d = HS_IDLE;
    endcase
    if (rd_i) begin
      unique case (addr_i)
        `CR_STATUS: rdata_d = link.status_flags_word;
        `CR_FAULT: rdata_d = link.fault_code_word;
        `CR_POS: rdata_d = link.jaw_position_word;
        `CR_MODE: rdata_d = {8'h00, mode_q};
        `CR_BASE: rdata_d = base_q;
        `CR_CTRL: rdata_d = {14'h0000, hs_q != HS_IDLE, go_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_q <= HS_IDLE;
      mode_q <= 8'h00;
      tol_q <= 8'h00;
      spd_q <= 8'h00;
      base_q <= `MIN_EXT_BASE;
      work_q <= 16'h0000;
      teach_q <= 16'h0000;
      go_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else if (clk_en_i) begin
      hs_q <= hs_d;
      mode_q <= mode_d;
      tol_q <= tol_d;
      spd_q <= spd_d;
      base_q <= base_d;
      work_q <= work_d;
      teach_q <= teach_d;
      go_q <= go_d;
      rdata_q <= rdata_d;
    end
  end

  assign link.host_command_word = (hs_q == HS_SEND) ? `CMD_XFER : `CMD_IDLE;
  assign link.operating_profile_code = mode_q;
  assign link.outer_limit_setpoint = base_q;
  assign link.inner_limit_setpoint = work_q;
  assign link.taught_target_setpoint = teach_q;
  assign link.window_half_width = tol_q;
  assign link.speed_percent_setpoint = spd_q;
  assign rdata_o = rdata_q;
endmodule // gripper_controller
`default_nettype wire

// file: rtl/gripper_device.sv
// gripper end: status word, fault code, jaw position and homing command decode
// Function
// - no window matched sets bit 11
// - bit 12 after latching on command 1
// - bit 13 last move toward outer
// - bit 14 last move toward inner
// - bit 15 on fault, code identifies it
// - fault code word always reported, 16 bit
// - jaw position word in 0.01 mm
// - modes 10,14,16,17 select homing runs
// - no external homing on safety-jaw variants
// - controller never homes while gripped
// - mode 10 outward to stop, zero, motor on
// - mode 14 same run, inward
// - mode 10 accepted with motor on or off
// - mode 3 first, it energises motor; this gripper energises the motor itself at the start of every homing run
// - mode 16 loads outer setpoint at stop
// - controller supplies outer setpoint at least 75
// - after mode 16 motor off, mode 3 needed; this gripper energises the motor itself when a mode 16 or 17 run starts
// - fault code zero after special homing
// - controller should lower speed before special homing
// - bit 1 while motor energised
// - bit 0 when reference valid
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "gripper_map.svh"
module gripper_device
  import gripper_pkg::*;
#(
  parameter int BOOT_CYC = `BOOT_CYCLES,
  parameter int STEP_CYC = `STEP_CYCLES,
  parameter bit SAFETY_JAWS = 1'b0
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // link
  gripper_if.gripper link,
  // mechanics
  input wire logic jaw_at_stop_i,
  input wire logic gripped_i,
  input wire logic drive_fault_i,
  input wire logic [15:0] drive_fault_code_i,
  // drive outputs
  output logic motor_on_o,
  output logic move_outer_o,
  output logic move_inner_o
);
  dev_state_e state_q, state_d;
  word_t pos_q, pos_d, fault_q, fault_d, base_q, base_d;
  logic [7:0] mode_q, mode_d;
  logic motor_q, motor_d, ref_q, ref_d, dir_out_q, dir_out_d, dir_in_q, dir_in_d;
  logic ack_q, ack_d, done_q, done_d;
  logic [15:0] cnt_q, cnt_d;
  logic stop_s1_q, stop_s2_q, flt_s1_q, flt_s2_q, grp_s1_q, grp_s2_q;
  word_t code_s1_q, code_s2_q;
  logic at_outer, at_inner, at_taught, no_window, cmd_go;

  // pins come from the mechanics, outside this clock domain
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
      flt_s1_q <= 1'b0;
      flt_s2_q <= 1'b0;
      grp_s1_q <= 1'b0;
      grp_s2_q <= 1'b0;
      code_s1_q <= 16'h0000;
      code_s2_q <= 16'h0000;
    end else if (clk_en_i) begin
      stop_s1_q <= jaw_at_stop_i;
      stop_s2_q <= stop_s1_q;
      flt_s1_q <= drive_fault_i;
      flt_s2_q <= flt_s1_q;
      grp_s1_q <= gripped_i;
      grp_s2_q <= grp_s1_q;
      // the code travels beside its flag so both arrive on the same cycle
      code_s1_q <= drive_fault_code_i;
      code_s2_q <= code_s1_q;
    end
  end

  jaw_window_check u_outer (.position_i(pos_q), .setpoint_i(link.outer_limit_setpoint),
    .half_width_i(link.window_half_width), .inside_o(at_outer));
  jaw_window_check u_inner (.position_i(pos_q), .setpoint_i(link.inner_limit_setpoint),
    .half_width_i(link.window_half_width), .inside_o(at_inner));
  jaw_window_check u_taught (.position_i(pos_q), .setpoint_i(link.taught_target_setpoint),
    .half_width_i(link.window_half_width), .inside_o(at_taught));

  assign no_window = !(at_outer || at_taught || at_inner);
  assign cmd_go = (link.host_command_word == `CMD_XFER);

  always_comb begin
    state_d = state_q;
    pos_d = pos_q;
    fault_d = fault_q;
    base_d = base_q;
    mode_d = mode_q;
    motor_d = motor_q;
    ref_d = ref_q;
    dir_out_d = dir_out_q;
    dir_in_d = dir_in_q;
    ack_d = ack_q;
    done_d = done_q;
    cnt_d = cnt_q;
    // a drive fault wins over any clear on the same cycle
    if (flt_s2_q) begin
      fault_d = code_s2_q;
    end
    unique case (state_q)
      DV_BOOT: begin
        if (cnt_q == 16'(BOOT_CYC - 1)) begin
          state_d = DV_IDLE;
          cnt_d = 16'h0000;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      DV_IDLE: begin
        if (cmd_go) begin
          mode_d = link.operating_profile_code;
          base_d = link.outer_limit_setpoint;
          done_d = 1'b0;
          state_d = DV_ACK;
          unique case (link.operating_profile_code)
            `MODE_MOTOR_ON: motor_d = 1'b1;
            `MODE_HOME_OUT, `MODE_HOME_IN, `MODE_HOME_EXT_OUT, `MODE_HOME_EXT_IN: begin
              if (grp_s2_q) begin
                fault_d = `FAULT_HOME_GRIPPED;
              end else if (SAFETY_JAWS && (link.operating_profile_code == `MODE_HOME_EXT_OUT ||
                  link.operating_profile_code == `MODE_HOME_EXT_IN)) begin
                fault_d = `FAULT_BAD_MODE;
              end else if (link.operating_profile_code == `MODE_HOME_EXT_OUT &&
                  link.outer_limit_setpoint < `MIN_EXT_BASE) begin
                fault_d = `FAULT_BAD_BASE;
              end else begin
                // mode 10 and 14 energise themselves whatever the motor was doing
                motor_d = 1'b1;
                ref_d = 1'b0;
                dir_out_d = (link.operating_profile_code == `MODE_HOME_OUT ||
                  link.operating_profile_code == `MODE_HOME_EXT_OUT);
                dir_in_d = !dir_out_d;
                state_d = DV_HOME_RUN;
              end
            end
            default: ;
          endcase
          if (state_d == DV_ACK) begin
            ack_d = 1'b1;
          end
        end
      end
      DV_HOME_RUN: begin
        // slow run: position steps one count each STEP_CYC cycles until the stop is felt
        if (stop_s2_q) begin
          ref_d = 1'b1;
          done_d = 1'b1;
          if (mode_q == `MODE_HOME_OUT || mode_q == `MODE_HOME_IN) begin
            pos_d = `POS_ZERO;
          end else begin
            pos_d = base_q;
            motor_d = 1'b0;
            if (!flt_s2_q) begin
              fault_d = `FAULT_NONE;
            end
          end
          ack_d = 1'b1;
          state_d = DV_ACK;
        end else if (cnt_q == 16'(STEP_CYC - 1)) begin
          cnt_d = 16'h0000;
          pos_d = dir_in_q ? pos_q + 16'h0001 : pos_q - 16'h0001;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      DV_ACK: begin
        if (!cmd_go) begin
          ack_d = 1'b0;
          state_d = DV_IDLE;
        end else begin
          state_d = DV_WAIT_CLR;
        end
      end
      DV_WAIT_CLR: begin
        if (!cmd_go) begin
          ack_d = 1'b0;
          state_d = DV_IDLE;
        end
      end
      default: state_d = DV_BOOT;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= DV_BOOT;
      pos_q <= `POS_ZERO;
      fault_q <= `FAULT_NONE;
      base_q <= `POS_ZERO;
      mode_q <= 8'h00;
      motor_q <= 1'b0;
      ref_q <= 1'b0;
      dir_out_q <= 1'b0;
      dir_in_q <= 1'b0;
      ack_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (clk_en_i) begin
      state_q <= state_d;
      pos_q <= pos_d;
      fault_q <= fault_d;
      base_q <= base_d;
      mode_q <= mode_d;
      motor_q <= motor_d;
      ref_q <= ref_d;
      dir_out_q <= dir_out_d;
      dir_in_q <= dir_in_d;
      ack_q <= ack_d;
      done_q <= done_d;
      cnt_q <= cnt_d;
    end
  end

  always_comb begin
    link.status_flags_word = 16'h0000;
    link.status_flags_word[`ST_REF_OK] = ref_q;
    link.status_flags_word[`ST_MOTOR] = motor_q;
    link.status_flags_word[`ST_IN_MOTION] = (state_q == DV_HOME_RUN);
    link.status_flags_word[`ST_DONE] = done_q;
    link.status_flags_word[`ST_PLC_ACTIVE] = (state_q != DV_BOOT);
    link.status_flags_word[`ST_AT_OUTER] = at_outer;
    link.status_flags_word[`ST_AT_TAUGHT] = at_taught;
    link.status_flags_word[`ST_AT_INNER] = at_inner;
    link.status_flags_word[`ST_NO_WINDOW] = no_window;
    link.status_flags_word[`ST_XFER_ACK] = ack_q;
    link.status_flags_word[`ST_DIR_OUTER] = dir_out_q;
    link.status_flags_word[`ST_DIR_INNER] = dir_in_q;
    link.status_flags_word[`ST_ERROR] = (fault_q != `FAULT_NONE);
  end
  assign link.fault_code_word = fault_q;
  assign link.jaw_position_word = pos_q;
  assign motor_on_o = motor_q;
  assign move_outer_o = (state_q == DV_HOME_RUN) && dir_out_q;
  assign move_inner_o = (state_q == DV_HOME_RUN) && dir_in_q;
endmodule // gripper_device
`default_nettype wire

// file: rtl/jaw_window_check.sv
// tolerance window compare of the jaw position against one setpoint
`timescale 1ns/1ps
`default_nettype none
module jaw_window_check
  import gripper_pkg::*;
(
  // compare operands
  input wire word_t position_i,
  input wire word_t setpoint_i,
  input wire logic [7:0] half_width_i,
  // result
  output logic inside_o
);
  logic [16:0] lo;
  logic [16:0] hi;
  always_comb begin
    lo = {1'b0, setpoint_i} - {9'h000, half_width_i};
    hi = {1'b0, setpoint_i} + {9'h000, half_width_i};
    // the low bound may go below zero; its borrow bit then means "no lower limit"
    inside_o = (lo[16] || {1'b0, position_i} >= lo) && ({1'b0, position_i} <= hi);
  end
endmodule // jaw_window_check
`default_nettype wire

// file: tb/gripper_checker.sv
// concurrent checks on the controller-gripper link signals
`timescale 1ns/1ps
`default_nettype none
`include "gripper_map.svh"
module gripper_checker
  import gripper_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // link
  input wire word_t host_command_word,
  input wire logic [7:0] operating_profile_code,
  input wire word_t outer_limit_setpoint,
  input wire word_t status_flags_word,
  input wire word_t fault_code_word,
  input wire word_t jaw_position_word
);
  wire word_t st = status_flags_word;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_no_window_flag: assert property (
    st[`ST_NO_WINDOW] == !(st[`ST_AT_OUTER] || st[`ST_AT_TAUGHT] || st[`ST_AT_INNER]))
    else $error("undefined-position flag disagrees with window flags");
  a_fault_flag_code: assert property (
    st[`ST_ERROR] == (fault_code_word != `FAULT_NONE))
    else $error("error flag disagrees with fault code");
  a_ack_needs_cmd: assert property (
    $rose(st[`ST_XFER_ACK]) |-> $past(host_command_word) == `CMD_XFER)
    else $error("ack rose without a transfer command");
  a_ack_holds: assert property (
    st[`ST_XFER_ACK] && host_command_word == `CMD_XFER |=> st[`ST_XFER_ACK])
    else $error("ack dropped while command still set");
  a_ack_drops: assert property (
    st[`ST_XFER_ACK] && host_command_word == `CMD_IDLE |=> !st[`ST_XFER_ACK])
    else $error("ack stayed after command cleared");
  a_out_dir: assert property (
    $rose(st[`ST_IN_MOTION]) && operating_profile_code == `MODE_HOME_OUT |-> st[`ST_DIR_OUTER] && !st[`ST_DIR_INNER])
    else $error("outward run without outer direction flag");
  a_in_dir: assert property (
    $rose(st[`ST_IN_MOTION]) && operating_profile_code == `MODE_HOME_IN |-> st[`ST_DIR_INNER] && !st[`ST_DIR_OUTER])
    else $error("inward run without inner direction flag");
  a_run_motor: assert property (
    st[`ST_IN_MOTION] |-> st[`ST_MOTOR] && !st[`ST_REF_OK])
    else $error("homing run with motor off or reference still valid");
  a_home_zero: assert property (
    $rose(st[`ST_REF_OK]) && (operating_profile_code == `MODE_HOME_OUT || operating_profile_code == `MODE_HOME_IN)
    |-> jaw_position_word == `POS_ZERO)
    else $error("internal homing did not zero position");
  a_ext_load: assert property (
    $rose(st[`ST_REF_OK]) && operating_profile_code == `MODE_HOME_EXT_OUT
    |-> jaw_position_word == outer_limit_setpoint && !st[`ST_MOTOR] && fault_code_word == `FAULT_NONE)
    else $error("external homing end state wrong");
endmodule // gripper_checker
`default_nettype wire

// file: tb/gripper_status_and_homing_control_tb.sv
// self-checking bench joining controller and gripper ends over the link
`timescale 1ns/1ps
`default_nettype none
`include "gripper_map.svh"
module gripper_status_and_homing_control_tb
  import gripper_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  word_t wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic jaw_at_stop_i = 1'b0;
  logic gripped_i = 1'b0;
  logic drive_fault_i = 1'b0;
  word_t drive_fault_code_i = 16'h0000;
  logic clk_en = 1'b1;
  logic motor_on_o;
  logic move_outer_o;
  logic move_inner_o;
  logic [1:0] run_dir = 2'b00;
  int fail_count = 0;
  int check_count = 0;
  int stop_dly = 4;
  int stop_cnt = 0;
  gripper_if gl();
  gripper_if gs();

  always #2 sys_clk_i = ~sys_clk_i;

  gripper_controller u_gripper_controller (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(gl.controller));
  gripper_device #(.BOOT_CYC(2), .STEP_CYC(1)) u_gripper_device (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en), .link(gl.gripper), .jaw_at_stop_i(jaw_at_stop_i), .gripped_i(gripped_i),
    .drive_fault_i(drive_fault_i), .drive_fault_code_i(drive_fault_code_i), .motor_on_o(motor_on_o),
    .move_outer_o(move_outer_o), .move_inner_o(move_inner_o));
  // safety-jaw variant fed by the bench directly, so it can be sent what no controller should send;
  // it shares the mechanics pins of the main end but is never let into a homing run
  gripper_device #(.BOOT_CYC(2), .STEP_CYC(1), .SAFETY_JAWS(1'b1)) u_gripper_device_safe (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .clk_en_i(clk_en), .link(gs.gripper), .jaw_at_stop_i(jaw_at_stop_i),
    .gripped_i(gripped_i), .drive_fault_i(drive_fault_i), .drive_fault_code_i(drive_fault_code_i),
    .motor_on_o(), .move_outer_o(), .move_inner_o());
  gripper_checker u_gripper_checker (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .host_command_word(gl.host_command_word), .operating_profile_code(gl.operating_profile_code),
    .outer_limit_setpoint(gl.outer_limit_setpoint), .status_flags_word(gl.status_flags_word),
    .fault_code_word(gl.fault_code_word), .jaw_position_word(gl.jaw_position_word));

  // jaws meet a stop some cycles into each run and leave it once the run ends
  always @(posedge sys_clk_i) begin
    if (gl.status_flags_word[`ST_IN_MOTION] === 1'b1) begin
      stop_cnt <= stop_cnt + 1;
      jaw_at_stop_i <= (stop_cnt >= stop_dly);
      run_dir <= {move_outer_o, move_inner_o};
    end else begin
      stop_cnt <= 0;
      jaw_at_stop_i <= 1'b0;
    end
  end

  task automatic chk(input word_t got, input word_t exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // strobes drop for one cycle between accesses so no signal is assigned twice at one edge
  task automatic wr(input logic [3:0] a, input word_t d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic rd(input logic [3:0] a, output word_t d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
    @(posedge sys_clk_i);
  endtask

  task automatic wait_bit(input bit safe, input int b, input logic v, input int lim);
    int n;
    n = 0;
    while ((safe ? gs.status_flags_word[b] : gl.status_flags_word[b]) !== v) begin
      if (n == lim) begin
        chk({15'h0000, ~v}, {15'h0000, v});
        tally_and_finish();
      end
      n++;
      @(posedge sys_clk_i);
    end
  endtask

  task automatic run(input logic [7:0] m, input word_t b);
    int n;
    word_t v;
    wr(`CR_MODE, {8'h00, m});
    wr(`CR_BASE, b);
    wr(`CR_GO, 16'h0001);
    wait_bit(1'b0, `ST_XFER_ACK, 1'b1, 2000);
    wait_bit(1'b0, `ST_XFER_ACK, 1'b0, 50);
    n = 0;
    do begin
      rd(`CR_CTRL, v);
      n++;
    end while (v[`CTRL_BUSY_BIT] !== 1'b0 && n < 20);
    chk({15'h0000, v[`CTRL_BUSY_BIT]}, 16'h0000);
    if (v[`CTRL_BUSY_BIT] !== 1'b0) begin
      tally_and_finish();
    end
  endtask

  function automatic word_t exp_pos(input logic [7:0] m, input word_t b);
    if (m == `MODE_HOME_EXT_OUT) begin
      return (b < `MIN_EXT_BASE) ? `MIN_EXT_BASE : b;
    end
    return `POS_ZERO;
  endfunction

  initial begin
    word_t v;
    word_t b;
    word_t dexp;
    logic [7:0] m;
    bit ext;
    logic [7:0] mt [6] = '{`MODE_HOME_OUT, `MODE_HOME_IN, `MODE_HOME_EXT_OUT, `MODE_HOME_EXT_IN,
      `MODE_HOME_OUT, `MODE_HOME_EXT_OUT};
    void'($urandom(16712));
    gs.host_command_word = `CMD_IDLE;
    gs.operating_profile_code = `MODE_HOME_EXT_IN;
    gs.outer_limit_setpoint = 16'h0064;
    gs.inner_limit_setpoint = 16'h0FA0;
    gs.taught_target_setpoint = 16'h0200;
    gs.window_half_width = 8'h32;
    gs.speed_percent_setpoint = 8'h0A;
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wait_bit(1'b0, `ST_PLC_ACTIVE, 1'b1, 100);
    wr(`CR_TOL, 16'($urandom_range(255)));
    wr(`CR_TEACH, 16'($urandom_range(500)));
    wr(`CR_SPEED, 16'h000A);
    run(`MODE_MOTOR_ON, 16'h0064);
    chk({15'h0000, gl.status_flags_word[`ST_MOTOR]}, 16'h0001);
    chk({15'h0000, motor_on_o}, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      m = mt[i];
      ext = (m == `MODE_HOME_EXT_OUT || m == `MODE_HOME_EXT_IN);
      b = (i == 5) ? 16'h0032 : 16'(75 + $urandom_range(1000));
      if (ext) begin
        run(`MODE_MOTOR_ON, b);
      end
      stop_dly = $urandom_range(12);
      run(m, b);
      v = gl.status_flags_word;
      chk({15'h0000, v[`ST_REF_OK]}, 16'h0001);
      chk({15'h0000, v[`ST_MOTOR]}, {15'h0000, !ext});
      chk({15'h0000, motor_on_o}, {15'h0000, !ext});
      dexp = (m == `MODE_HOME_OUT || m == `MODE_HOME_EXT_OUT) ? 16'h0002 : 16'h0001;
      chk({14'h0000, run_dir}, dexp);
      chk({14'h0000, v[`ST_DIR_OUTER], v[`ST_DIR_INNER]}, dexp);
      if (m != `MODE_HOME_EXT_IN) begin
        rd(`CR_POS, v);
        chk(v, exp_pos(m, b));
      end
      rd(`CR_FAULT, v);
      chk(v, `FAULT_NONE);
    end
    gripped_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    run(`MODE_HOME_OUT, 16'h0064);
    rd(`CR_FAULT, v);
    chk(v, `FAULT_HOME_GRIPPED);
    chk({15'h0000, gl.status_flags_word[`ST_ERROR]}, 16'h0001);
    gripped_i <= 1'b0;
    // let the released grip pass the synchronisers before the safe end is asked
    repeat (4) @(posedge sys_clk_i);
    gs.host_command_word <= `CMD_XFER;
    wait_bit(1'b1, `ST_XFER_ACK, 1'b1, 100);
    chk(gs.fault_code_word, `FAULT_BAD_MODE);
    gs.host_command_word <= `CMD_IDLE;
    wait_bit(1'b1, `ST_XFER_ACK, 1'b0, 50);
    b = 16'($urandom);
    drive_fault_code_i <= b;
    drive_fault_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    chk(gl.fault_code_word, b);
    chk({15'h0000, gl.status_flags_word[`ST_ERROR]}, {15'h0000, b != 16'h0000});
    // with the enable low a new drive code must not reach the fault word
    clk_en <= 1'b0;
    drive_fault_code_i <= ~b;
    repeat (6) @(posedge sys_clk_i);
    chk(gl.fault_code_word, b);
    clk_en <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    chk(gl.fault_code_word, ~b);
    tally_and_finish();
  end
endmodule // gripper_status_and_homing_control_tb
`default_nettype wire
